/* psq_pkg.sv */
// How it works
// - Four phases make one instruction cycle
// - Fetch next word while current one executes
// - Program counter changes cost a dummy cycle
// - Program counter steps by one per fetch
// - True skip discards prefetched word
// - Low counter byte write jumps in page
// - Reset clears program counter to zero
// - External interrupt vectors to its entry
// - Counter 0 overflow vectors to entry
// - Counter 1 overflow vectors to entry
// - Jump and call load instruction address
// - Returns reload counter from stack top
// - Program memory addressed by counter or pointer
// - Table page from counter or forced ones
// - Table word splits to data and high
// - Lookup pointer is read-write word address
// - Table reads take two instruction cycles
// - Start-up delay of 1024 clocks
// - Mask interrupts around unsaved table reads
// - Calls and interrupts push the counter
`default_nettype none
package psq_pkg;
    // Register offsets
    localparam logic [7:0] PSQ_OFS_PROG_LOW = 8'h06;
    localparam logic [7:0] PSQ_OFS_LOOKUP_PTR = 8'h07;
    localparam logic [7:0] PSQ_OFS_LOOKUP_HIGH = 8'h08;
    // Fixed program entries
    localparam logic [11:0] PSQ_VEC_RESET = 12'h000;
    localparam logic [11:0] PSQ_VEC_EXT = 12'h004;
    localparam logic [11:0] PSQ_VEC_CNT0 = 12'h008;
    localparam logic [11:0] PSQ_VEC_CNT1 = 12'h00c;
    // Last page of table reads
    localparam logic [3:0] PSQ_LAST_PAGE = 4'hf;
    // Reset values
    localparam logic [7:0] PSQ_RST_BYTE = 8'h00;
    // Clock periods per instruction cycle
    localparam int PSQ_PHASES = 4;
    // Start-up time in system clock periods
    localparam int PSQ_SST_PERIODS = 1024;
    localparam int PSQ_SYS_NS = 25;
    localparam int PSQ_CLK_NS = 25;
    localparam int PSQ_SST_CYC =
        (PSQ_SST_PERIODS * PSQ_SYS_NS + PSQ_CLK_NS - 1) / PSQ_CLK_NS;
    localparam logic [9:0] PSQ_SST_LAST = 10'(PSQ_SST_CYC - 1);
    // Phase walk, Gray coded
    typedef enum logic [1:0] {
        PSQ_P0 = 2'b00,
        PSQ_P1 = 2'b01,
        PSQ_P2 = 2'b11,
        PSQ_P3 = 2'b10
    } psq_phase_e;
    // Decoded flow operations
    typedef enum logic [2:0] {
        PSQ_OP_NONE = 3'h0,
        PSQ_OP_JUMP = 3'h1,
        PSQ_OP_CALL = 3'h2,
        PSQ_OP_RET = 3'h3,
        PSQ_OP_RETI = 3'h4,
        PSQ_OP_SKIP = 3'h5,
        PSQ_OP_TRDC = 3'h6,
        PSQ_OP_TRDL = 3'h7
    } psq_op_e;
    // Command from the instruction decoder
    typedef struct packed {
        psq_op_e op;
        logic [11:0] target;
    } psq_cmd_s;
    // Interrupt requests, enables, stack state
    typedef struct packed {
        logic [2:0] req;
        logic [2:0] en;
        logic full;
    } psq_irq_s;
    // Whole sequencer state
    typedef struct packed {
        psq_phase_e ph;
        logic run;
        logic [9:0] cnt;
        logic [11:0] pc;
        logic [11:0] fa;
        logic [11:0] ex;
        logic [14:0] ir;
        logic fv;
        logic irv;
        logic stall;
        logic exv;
        logic [11:0] tbla;
        logic [7:0] lptr;
        logic [7:0] lhigh;
        logic pclp;
        logic [7:0] pclv;
        logic [11:0] rom;
        logic [7:0] rdata;
        logic push;
        logic pop;
        logic [11:0] pa;
        logic [2:0] ack;
        logic twe;
        logic [7:0] tdat;
    } psq_state_s;
endpackage
`default_nettype wire

/* psq_sequencer.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [11:0] ROM_ADDR,
    input wire logic [14:0] ROM_DATA,
    output logic [14:0] INSTR,
    output logic EXEC_VALID,
    output logic [1:0] PHASE,
    input wire psq_pkg::psq_cmd_s CMD,
    input wire psq_pkg::psq_irq_s IRQ,
    output logic [2:0] IRQ_ACK,
    input wire logic [11:0] STACK_TOP,
    output logic PUSH,
    output logic POP,
    output logic [11:0] PUSH_ADDR,
    output logic TBL_WE,
    output logic [7:0] TBL_DATA,
    input wire logic WAKE,
    output logic RUNNING
);

    // Next phase along the Gray walk
    function automatic psq_pkg::psq_phase_e ph_next(
        input psq_pkg::psq_phase_e p
    );
        case (p)
            psq_pkg::PSQ_P0: ph_next = psq_pkg::PSQ_P1;
            psq_pkg::PSQ_P1: ph_next = psq_pkg::PSQ_P2;
            psq_pkg::PSQ_P2: ph_next = psq_pkg::PSQ_P3;
            default: ph_next = psq_pkg::PSQ_P0;
        endcase
    endfunction

    // Qualified request that wins, one-hot
    function automatic logic [2:0] irq_pick(
        input psq_pkg::psq_irq_s q
    );
        logic [2:0] live;
        live = q.req & q.en & {3{~q.full}};
        if (live[0]) begin
            irq_pick = 3'b001;
        end else if (live[1]) begin
            irq_pick = 3'b010;
        end else if (live[2]) begin
            irq_pick = 3'b100;
        end else begin
            irq_pick = 3'b000;
        end
    endfunction

    // Entry address for a one-hot grant
    function automatic logic [11:0] irq_vec(input logic [2:0] g);
        if (g[0]) begin
            irq_vec = psq_pkg::PSQ_VEC_EXT;
        end else if (g[1]) begin
            irq_vec = psq_pkg::PSQ_VEC_CNT0;
        end else begin
            irq_vec = psq_pkg::PSQ_VEC_CNT1;
        end
    endfunction

    // Registered and next state
    psq_pkg::psq_state_s s_reg;
    psq_pkg::psq_state_s s_next;
    // Flow decisions at the cycle boundary
    logic flush;
    logic [11:0] tgt;
    logic [2:0] grant;
    logic bnd;
    logic exe;
    logic [11:0] jmp_short; // Short jump destination
    logic [11:0] tbl_cur; // Current page table address

    // Boundary of an executing cycle
    assign bnd = s_reg.run && s_reg.ph == psq_pkg::PSQ_P3 && !s_reg.stall;
    assign exe = bnd && s_reg.irv && !s_reg.pclp;
    // Addresses the checks compare against
    assign jmp_short = {s_reg.ex[11:8], s_reg.pclv};
    assign tbl_cur = {s_reg.ex[11:8], s_reg.lptr};

    // Next state
    always_comb begin
        s_next = s_reg;
        flush = 1'b0;
        tgt = s_reg.pc;
        grant = 3'b000;
        // Pulses default low
        s_next.push = 1'b0;
        s_next.pop = 1'b0;
        s_next.ack = 3'b000;
        s_next.twe = 1'b0;
        s_next.rdata = psq_pkg::PSQ_RST_BYTE;
        if (!s_reg.run) begin
            // Start-up timer holds execution off
            if (s_reg.cnt == psq_pkg::PSQ_SST_LAST) begin
                s_next.run = 1'b1;
                s_next.ph = psq_pkg::PSQ_P0;
            end else begin
                s_next.cnt = s_reg.cnt + 10'h001;
            end
        end else begin
            // Four clock phases per cycle
            s_next.ph = ph_next(s_reg.ph);
            if (s_reg.ph == psq_pkg::PSQ_P3 && s_reg.stall) begin
                // Second cycle of a table read
                s_next.stall = 1'b0;
                s_next.twe = 1'b1;
                s_next.tdat = ROM_DATA[7:0];
                // High part lands low, top bit zero
                s_next.lhigh = {1'b0, ROM_DATA[14:8]};
                s_next.rom = s_reg.pc;
                s_next.fa = s_reg.pc;
                s_next.pc = s_reg.pc + 12'h001;
                s_next.fv = 1'b1;
            end else if (s_reg.ph == psq_pkg::PSQ_P3) begin
                if (s_reg.pclp) begin
                    // Short jump inside the current page
                    tgt = {s_reg.ex[11:8], s_reg.pclv};
                    flush = 1'b1;
                    s_next.pclp = 1'b0;
                end else if (s_reg.irv) begin
                    case (CMD.op)
                        psq_pkg::PSQ_OP_JUMP: begin
                            tgt = CMD.target;
                            flush = 1'b1;
                        end
                        psq_pkg::PSQ_OP_CALL: begin
                            tgt = CMD.target;
                            flush = 1'b1;
                            s_next.push = 1'b1;
                            s_next.pa = s_reg.fa;
                        end
                        psq_pkg::PSQ_OP_RET,
                        psq_pkg::PSQ_OP_RETI: begin
                            tgt = STACK_TOP;
                            flush = 1'b1;
                            s_next.pop = 1'b1;
                        end
                        psq_pkg::PSQ_OP_SKIP: begin
                            // Counter already two past the skip
                            flush = 1'b1;
                        end
                        psq_pkg::PSQ_OP_TRDC: begin
                            s_next.stall = 1'b1;
                            s_next.tbla = {s_reg.ex[11:8], s_reg.lptr};
                        end
                        psq_pkg::PSQ_OP_TRDL: begin
                            s_next.stall = 1'b1;
                            s_next.tbla = {psq_pkg::PSQ_LAST_PAGE, s_reg.lptr};
                        end
                        default: begin
                            // Plain instruction, nothing to steer
                        end
                    endcase
                end
                // Interrupt taken only on a plain boundary
                if (!flush && !s_next.stall && s_reg.fv) begin
                    grant = irq_pick(IRQ);
                    if (grant != 3'b000) begin
                        tgt = irq_vec(grant);
                        flush = 1'b1;
                        s_next.ack = grant;
                        s_next.push = 1'b1;
                        s_next.pa = s_reg.fa;
                    end
                end
                // Prefetched word moves to execution
                s_next.ir = ROM_DATA;
                s_next.ex = s_reg.fa;
                s_next.irv = s_reg.fv && !flush;
                if (s_next.stall) begin
                    // Memory serves the table next cycle
                    s_next.rom = s_next.tbla;
                end else begin
                    s_next.rom = tgt;
                    s_next.fa = tgt;
                    s_next.pc = tgt + 12'h001;
                    s_next.fv = 1'b1;
                end
            end
        end
        // Register reads
        if (REG_RD) begin
            case (REG_ADDR)
                psq_pkg::PSQ_OFS_PROG_LOW: s_next.rdata = s_reg.ex[7:0];
                psq_pkg::PSQ_OFS_LOOKUP_PTR: s_next.rdata = s_reg.lptr;
                psq_pkg::PSQ_OFS_LOOKUP_HIGH: s_next.rdata = s_reg.lhigh;
                default: s_next.rdata = psq_pkg::PSQ_RST_BYTE;
            endcase
        end
        // Register writes, high byte is read-only
        if (REG_WR) begin
            case (REG_ADDR)
                psq_pkg::PSQ_OFS_PROG_LOW: begin
                    s_next.pclp = 1'b1;
                    s_next.pclv = REG_WDATA;
                end
                psq_pkg::PSQ_OFS_LOOKUP_PTR: s_next.lptr = REG_WDATA;
                default: begin
                    // Writes elsewhere are ignored
                end
            endcase
        end
        // Wake from halt restarts the start-up timer
        if (WAKE) begin
            s_next.run = 1'b0;
            s_next.cnt = 10'h000;
            s_next.ph = psq_pkg::PSQ_P0;
            s_next.stall = 1'b0;
            s_next.pc = s_reg.fa;
            s_next.fv = 1'b0;
            s_next.irv = 1'b0;
        end
        // Execute strobe for the decoder
        s_next.exv = s_next.run && s_next.irv && !s_next.stall;
    end

    // State register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.pc <= psq_pkg::PSQ_VEC_RESET;
            s_reg.ph <= psq_pkg::PSQ_P0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Ports straight from the state flops
    assign REG_RDATA = s_reg.rdata;
    assign ROM_ADDR = s_reg.rom;
    assign INSTR = s_reg.ir;
    assign EXEC_VALID = s_reg.exv;
    assign PHASE = s_reg.ph;
    assign IRQ_ACK = s_reg.ack;
    assign PUSH = s_reg.push;
    assign POP = s_reg.pop;
    assign PUSH_ADDR = s_reg.pa;
    assign TBL_WE = s_reg.twe;
    assign TBL_DATA = s_reg.tdat;
    assign RUNNING = s_reg.run;

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // Phase zero then two quiet cycles
    sequence s_quiet;
        (s_reg.run && s_reg.ph == psq_pkg::PSQ_P0 && !WAKE) ##1 (!WAKE)[*2];
    endsequence

    // Table read issued without wake
    sequence s_trd;
        exe && !WAKE && (CMD.op == psq_pkg::PSQ_OP_TRDC ||
            CMD.op == psq_pkg::PSQ_OP_TRDL);
    endsequence

    a_phase_walk: assert property (s_quiet |=> s_reg.ph == psq_pkg::PSQ_P3)
        else $error("phase walk broken");

    a_pc_step: assert property (bnd && !flush && !s_next.stall && !WAKE
        |=> s_reg.pc == $past(s_reg.pc) + 12'h001)
        else $error("counter did not advance");

    a_reset_pc: assert property ($fell(RST) |-> s_reg.pc == 12'h000)
        else $error("counter not cleared");

    a_ext_vec: assert property (IRQ_ACK == 3'b001
        |-> ROM_ADDR == psq_pkg::PSQ_VEC_EXT && PUSH)
        else $error("external entry wrong");

    a_cnt0_vec: assert property (IRQ_ACK == 3'b010
        |-> ROM_ADDR == psq_pkg::PSQ_VEC_CNT0 && PUSH)
        else $error("counter 0 entry wrong");

    a_cnt1_vec: assert property (IRQ_ACK == 3'b100
        |-> ROM_ADDR == psq_pkg::PSQ_VEC_CNT1 && PUSH)
        else $error("counter 1 entry wrong");

    a_jump_load: assert property (exe && !WAKE && CMD.op == psq_pkg::PSQ_OP_JUMP
        |=> ROM_ADDR == $past(CMD.target) && !s_reg.irv)
        else $error("jump target not loaded");

    a_ret_load: assert property (exe && !WAKE && CMD.op == psq_pkg::PSQ_OP_RET
        |=> POP && ROM_ADDR == $past(STACK_TOP))
        else $error("return address not loaded");

    a_skip_flush: assert property (exe && !WAKE && CMD.op == psq_pkg::PSQ_OP_SKIP
        |=> !s_reg.irv && ROM_ADDR == $past(s_reg.pc))
        else $error("skip did not discard");

    a_table_two: assert property (s_trd ##1 (!WAKE && !EXEC_VALID)[*4]
        |=> TBL_WE)
        else $error("table read not two cycles");

    a_high_top: assert property (REG_RD && REG_ADDR == psq_pkg::PSQ_OFS_LOOKUP_HIGH
        |=> REG_RDATA[7] == 1'b0)
        else $error("high byte top bit set");

    a_sst_len: assert property ($rose(s_reg.run)
        |-> $past(s_reg.cnt) == psq_pkg::PSQ_SST_LAST)
        else $error("start-up delay wrong");

    // Read data only in the cycle after a strobe
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");

    // Pointer takes the written byte
    a_ptr_write: assert property (REG_WR && REG_ADDR == psq_pkg::PSQ_OFS_LOOKUP_PTR
        |=> s_reg.lptr == $past(REG_WDATA))
        else $error("pointer write lost");

    // Pointer reads back
    a_ptr_read: assert property (REG_RD && REG_ADDR == psq_pkg::PSQ_OFS_LOOKUP_PTR
        |=> REG_RDATA == $past(s_reg.lptr))
        else $error("pointer read wrong");

    // Writes cannot touch the read-only high byte
    a_high_ro: assert property (REG_WR && REG_ADDR == psq_pkg::PSQ_OFS_LOOKUP_HIGH
        && !(s_reg.stall && s_reg.ph == psq_pkg::PSQ_P3)
        |=> $stable(s_reg.lhigh))
        else $error("high byte written");

    // Prefetched word moves into execution
    a_pipe_word: assert property (bnd |=> INSTR == $past(ROM_DATA))
        else $error("fetched word not passed on");

    // Transfers leave a dummy cycle
    a_dummy_xfer: assert property (exe && !WAKE && CMD.op inside {
        psq_pkg::PSQ_OP_JUMP, psq_pkg::PSQ_OP_CALL,
        psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETI} |=> !EXEC_VALID)
        else $error("no dummy cycle");

    // Short jump stays inside the page
    a_short_jump: assert property (bnd && s_reg.pclp
        |=> ROM_ADDR == $past(jmp_short) && !EXEC_VALID)
        else $error("short jump wrong");

    // Call saves the following word address
    a_call_push: assert property (exe && !WAKE && CMD.op == psq_pkg::PSQ_OP_CALL
        |=> PUSH && PUSH_ADDR == $past(s_reg.fa) && ROM_ADDR == $past(CMD.target))
        else $error("call push wrong");

    // Current page table address
    a_trd_cur: assert property (exe && CMD.op == psq_pkg::PSQ_OP_TRDC
        |=> ROM_ADDR == $past(tbl_cur))
        else $error("current page table address wrong");

    // Last page table address
    a_trd_last: assert property (exe && CMD.op == psq_pkg::PSQ_OP_TRDL
        |=> ROM_ADDR == {psq_pkg::PSQ_LAST_PAGE, $past(s_reg.lptr)})
        else $error("last page table address wrong");

    // External request wins any grant
    a_ext_first: assert property (grant != 3'b000 && IRQ.req[0] && IRQ.en[0]
        |=> IRQ_ACK == 3'b001)
        else $error("external not first");

    // Counter 0 beats counter 1
    a_cnt0_first: assert property (grant != 3'b000 && !(IRQ.req[0] && IRQ.en[0])
        && IRQ.req[1] && IRQ.en[1] |=> IRQ_ACK == 3'b010)
        else $error("counter 0 not before counter 1");

    // Full stack holds every request off
    a_full_block: assert property (IRQ.full |=> IRQ_ACK == 3'b000)
        else $error("grant with full stack");

endmodule
`default_nettype wire

/* psq_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Program memory and flow decoder beside the sequencer
module psq_rom_model (
    input wire logic [11:0] rom_addr,
    output logic [14:0] rom_data,
    input wire logic [14:0] instr,
    output psq_pkg::psq_cmd_s cmd
);
    // Whole program space, 15-bit words
    logic [14:0] mem [4096];
    // Test program: top three bits are the flow op, rest the target
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = {3'h0, 12'(i)};
        end
        mem[12'h001] = 15'h1020; // Jump to 0x020
        mem[12'h020] = 15'h2040; // Call 0x040
        mem[12'h040] = 15'h5040; // Skip taken
        mem[12'h042] = 15'h6042; // Table read, current page
        mem[12'h043] = 15'h7043; // Table read, last page
        mem[12'h044] = 15'h3044; // Return
        mem[12'h023] = 15'h1022; // Idle loop back edge
        mem[12'h031] = 15'h1022; // Leave short jump area
        mem[12'h055] = 15'h7abc; // Table word, page zero
        mem[12'hf55] = 15'h1234; // Table word, last page
        mem[12'h004] = 15'h4004; // Service entries return at once
        mem[12'h008] = 15'h4008;
        mem[12'h00c] = 15'h400c;
    end
    // Asynchronous read, settled long before phase three
    assign rom_data = mem[rom_addr];
    // Decoder splits the executing word
    always_comb begin
        cmd.op = psq_pkg::psq_op_e'(instr[14:12]);
        cmd.target = instr[11:0];
    end
endmodule
`default_nettype wire

/* program_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_tb;
    logic CORE_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, WAKE = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, TBL_DATA;
    logic [11:0] STACK_TOP = 12'h000, ROM_ADDR, PUSH_ADDR;
    logic [14:0] ROM_DATA, INSTR;
    logic EXEC_VALID, PUSH, POP, TBL_WE, RUNNING;
    logic [1:0] PHASE;
    logic [2:0] IRQ_ACK;
    psq_pkg::psq_irq_s IRQ = '0;
    psq_pkg::psq_cmd_s CMD;
    int fails = 0, checks_done = 0;
    logic [11:0] stk[$], pushes[$]; // Return stack and push log
    logic [7:0] tq[$]; // Table bytes written
    // Per instruction cycle: bit 15 valid, low bits the word
    logic [15:0] rows [20] = '{16'h8000, 16'h9020, 16'h0000, 16'ha040, 16'h0000,
        16'hd040, 16'h0000, 16'he042, 16'h0000, 16'hf043, 16'h0000, 16'hb044,
        16'h0000, 16'h8021, 16'h8022, 16'h9022, 16'h0000, 16'h8022, 16'h9022, 16'h0000};
    // Interrupt cases: req, en, full, then expected grant
    logic [9:0] itab [5] = '{10'h3f1, 10'h372, 10'h274, 10'h380, 10'h3f8};
    psq_sequencer psq_sequencer_inst (.CORE_CLK(CORE_CLK), .RST(RST),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA), .INSTR(INSTR),
        .EXEC_VALID(EXEC_VALID), .PHASE(PHASE), .CMD(CMD), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK),
        .STACK_TOP(STACK_TOP), .PUSH(PUSH), .POP(POP), .PUSH_ADDR(PUSH_ADDR),
        .TBL_WE(TBL_WE), .TBL_DATA(TBL_DATA), .WAKE(WAKE), .RUNNING(RUNNING));
    psq_rom_model psq_rom_model_inst (.rom_addr(ROM_ADDR), .rom_data(ROM_DATA),
        .instr(INSTR), .cmd(CMD));
    // System clock, 25 ns
    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    // Stack model and table byte capture
    always @(posedge CORE_CLK) begin
        if (PUSH === 1'b1) begin
            stk.push_back(PUSH_ADDR);
            pushes.push_back(PUSH_ADDR);
        end
        if (POP === 1'b1 && stk.size() > 0) void'(stk.pop_back());
        if (TBL_WE === 1'b1) tq.push_back(TBL_DATA);
        STACK_TOP <= (stk.size() > 0) ? stk[$] : 12'h000;
    end
    // Verdict and end of run
    task automatic conclude;
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Single compare for all values
    task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Settle past the next edge
    task automatic tick;
        @(posedge CORE_CLK);
        #1;
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    // Register read, data in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask
    // Next phase zero cycle, with cycles waited
    task automatic next_p0(output logic v, output logic [14:0] w, output int n);
        n = 0;
        do begin
            tick;
            n++;
        end while (PHASE !== 2'b00 && n < 8);
        v = EXEC_VALID;
        w = INSTR;
    endtask
    // Next executed word, bounded
    task automatic next_exec(output logic [14:0] w);
        logic v;
        int n;
        for (int k = 0; k < 6; k++) begin
            next_p0(v, w, n);
            if (v === 1'b1) return;
        end
        chk("execution start", 15'h1, 15'h0);
    endtask
    // Raise one interrupt pattern and watch the grant
    task automatic irq_case(input logic [6:0] q, input logic [2:0] ea);
        logic [2:0] got;
        logic [14:0] w;
        logic [11:0] vec;
        got = 3'h0;
        vec = ea[0] ? psq_pkg::PSQ_VEC_EXT : (ea[1] ? psq_pkg::PSQ_VEC_CNT0 :
            psq_pkg::PSQ_VEC_CNT1);
        @(posedge CORE_CLK);
        IRQ <= q;
        for (int k = 0; k < 60 && got === 3'h0; k++) begin
            tick;
            got = IRQ_ACK;
        end
        @(posedge CORE_CLK);
        IRQ <= '0;
        chk("irq grant", 15'(ea), 15'(got));
        if (ea != 3'h0) begin
            next_exec(w);
            chk("vector word", {3'h4, vec}, w);
        end
        repeat (40) @(posedge CORE_CLK);
    endtask
    // Watchdog over the whole run
    initial begin
        repeat (4000) @(posedge CORE_CLK);
        fails++;
        conclude;
    end
    // Main sequence
    initial begin
        logic [7:0] d;
        logic v;
        logic [14:0] w;
        int n;
        repeat (10) @(posedge CORE_CLK);
        RST <= 1'b0;
        wr(8'h07, 8'h55);
        rd(8'h07, d);
        chk("pointer", 15'h55, 15'(d));
        rd(8'h20, d);
        chk("unmapped read", 15'h0, 15'(d));
        n = 0;
        while (RUNNING !== 1'b1 && n < 1100) begin
            tick;
            n++;
        end
        chk("startup span", 15'h1, 15'(n > 1013 && n < 1023));
        chk("first fetch", 15'h0, 15'(ROM_ADDR));
        next_exec(w);
        chk("instr", rows[0][14:0], w);
        for (int i = 1; i < 20; i++) begin
            next_p0(v, w, n);
            chk("cycle length", 15'h4, 15'(n));
            chk("exec valid", 15'(rows[i][15]), 15'(v));
            if (rows[i][15]) chk("instr", rows[i][14:0], w);
        end
        chk("table count", 15'h2, 15'(tq.size()));
        chk("table low current", 15'hbc, 15'(tq[0]));
        chk("table low last", 15'h34, 15'(tq[1]));
        wr(8'h08, 8'hff);
        rd(8'h08, d);
        chk("high byte", 15'h12, 15'(d));
        chk("call return address", 15'h021, 15'(pushes[0]));
        n = 0;
        do begin
            tick;
            n++;
        end while (PHASE !== 2'b01 && n < 8);
        wr(8'h06, 8'h30);
        next_exec(w);
        chk("short jump", 15'h0030, w);
        rd(8'h06, d);
        chk("low counter read", 15'h30, 15'(d));
        for (int i = 0; i < 5; i++) begin
            irq_case(itab[i][9:3], itab[i][2:0]);
        end
        @(posedge CORE_CLK);
        WAKE <= 1'b1;
        @(posedge CORE_CLK);
        WAKE <= 1'b0;
        #1;
        n = 0;
        while (RUNNING !== 1'b1 && n < 1100) begin
            tick;
            n++;
        end
        chk("wake span", 15'(psq_pkg::PSQ_SST_PERIODS), 15'(n));
        next_exec(w);
        chk("wake resumes", 15'h1, 15'(EXEC_VALID));
        @(posedge CORE_CLK);
        RST <= 1'b1;
        tick;
        chk("reset phase", 15'h0, 15'(PHASE));
        chk("reset address", 15'h0, 15'(ROM_ADDR));
        chk("reset running", 15'h0, 15'(RUNNING));
        conclude;
    end
endmodule
`default_nettype wire
